/* scan_tester.sv */
// Outside tester: 12 ns test clock, resting low between frames.
// Pins move 3 ns after the falling edge; tdo is read before rising.
`default_nettype none
module scan_tester (
    output logic      test_clk,
    output logic      test_mode_sel,
    output logic      test_data_in,
    input  wire logic test_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle levels match the pull-ups on the mode and data inputs
    initial begin
        test_clk = 1'h0;
        test_mode_sel = 1'h1;
        test_data_in = 1'h1;
    end
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        test_mode_sel = tms;
        test_data_in = tdi;
        #3 tdo = test_data_out;
        test_clk = 1'h1;
        #6 test_clk = 1'h0;
        #3;
    endtask
    // First edge is the power-up reset, five more reach test-logic-reset
    task automatic tap_reset();
        logic b;
        repeat (6) step(1'h1, 1'h1, b);
        step(1'h0, 1'h1, b);
    endtask
    // From idle: capture, shift n bits LSB first, update, back to idle
    task automatic scan(input logic ir, input int n,
                        input logic [68:0] din, output logic [68:0] dout);
        logic b;
        step(1'h1, 1'h1, b);
        if (ir) step(1'h1, 1'h1, b);
        step(1'h0, 1'h1, b);
        step(1'h0, 1'h1, b);
        dout = '0;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
        step(1'h1, 1'h1, b);
        step(1'h0, 1'h1, b);
    endtask
endmodule // scan_tester
`default_nettype wire

/* sram_tap_scan_registers.sv */
// Test access port: state machine, instruction, bypass, ID and boundary
// scan registers. Runs on the test clock; high-Z request is synchronised
// into the system clock domain for the memory output drivers.
`default_nettype none
module sram_tap_scan_registers
    import tap_scan_pkg::*;
#(
    parameter logic [ID_WIDTH-1:0] ID_CODE = ID_CODE_DEFAULT
) (
    // System clock side
    input  wire logic                 mclk,
    input  wire logic                 srst,
    input  wire logic                 clk_en,
    output logic                      outputs_high_z,
    // Test port
    input  wire logic                 test_clk,
    input  wire logic                 test_mode_sel,
    input  wire logic                 test_data_in,
    output logic                      test_data_out,
    output logic                      test_data_out_oe,
    // Pin levels sampled into the chain
    input  wire logic [BSR_WIDTH-1:0] io_ring
);
    import tap_scan_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        tap_state_e             state;
        logic [IR_WIDTH-1:0]    ir_shift;
        logic [IR_WIDTH-1:0]    scan_instruction;
        logic                   scan_bypass;
        logic [ID_WIDTH-1:0]    part_identification;
        logic [BSR_WIDTH-1:0]   pin_boundary_chain;
        logic                   highz;
    } tap_s;

    tap_s t_reg, t_next;
    logic por_done_reg = 1'b0;

    logic scan_op;
    logic serial_bit;
    // Serial output starts disabled, so test_data_out is held low from power-up until the first shift state
    logic tdo_reg    = 1'b0;
    logic tdo_oe_reg = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Test-clock domain
    always_comb begin
        t_next  = t_reg;
        scan_op = (t_reg.scan_instruction == OP_EXTEST)  ||
                  (t_reg.scan_instruction == OP_SAMPLE)  ||
                  (t_reg.scan_instruction == OP_SAMPLEZ);
        case (t_reg.state)
            TLR:    t_next.state = test_mode_sel ? TLR : RTI;
            RTI:    t_next.state = test_mode_sel ? SEL_DR : RTI;
            SEL_DR: t_next.state = test_mode_sel ? SEL_IR : CAP_DR;
            CAP_DR: t_next.state = test_mode_sel ? EX1_DR : SH_DR;
            SH_DR:  t_next.state = test_mode_sel ? EX1_DR : SH_DR;
            EX1_DR: t_next.state = test_mode_sel ? UP_DR : PA_DR;
            PA_DR:  t_next.state = test_mode_sel ? EX2_DR : PA_DR;
            EX2_DR: t_next.state = test_mode_sel ? UP_DR : SH_DR;
            UP_DR:  t_next.state = test_mode_sel ? SEL_DR : RTI;
            SEL_IR: t_next.state = test_mode_sel ? TLR : CAP_IR;
            CAP_IR: t_next.state = test_mode_sel ? EX1_IR : SH_IR;
            SH_IR:  t_next.state = test_mode_sel ? EX1_IR : SH_IR;
            EX1_IR: t_next.state = test_mode_sel ? UP_IR : PA_IR;
            PA_IR:  t_next.state = test_mode_sel ? EX2_IR : PA_IR;
            EX2_IR: t_next.state = test_mode_sel ? UP_IR : SH_IR;
            UP_IR:  t_next.state = test_mode_sel ? SEL_DR : RTI;
            default: t_next.state = TLR;
        endcase
        case (t_reg.state)
            TLR: begin
                t_next.scan_instruction = OP_IDCODE;
            end
            CAP_IR: begin
                t_next.ir_shift = {t_reg.scan_instruction[2],
                                   IR_CAPTURE};
            end
            SH_IR: begin
                t_next.ir_shift = {test_data_in,
                                   t_reg.ir_shift[IR_WIDTH-1:1]};
            end
            UP_IR: begin
                t_next.scan_instruction = t_reg.ir_shift;
            end
            CAP_DR: begin
                if (scan_op) begin
                    t_next.pin_boundary_chain = io_ring;
                end else if (t_reg.scan_instruction == OP_IDCODE) begin
                    t_next.part_identification = ID_CODE;
                end else begin
                    t_next.scan_bypass = 1'b0;
                end
            end
            SH_DR: begin
                if (scan_op) begin
                    t_next.pin_boundary_chain = {test_data_in,
                        t_reg.pin_boundary_chain[BSR_WIDTH-1:1]};
                end else if (t_reg.scan_instruction == OP_IDCODE) begin
                    t_next.part_identification = {test_data_in,
                        t_reg.part_identification[ID_WIDTH-1:1]};
                end else begin
                    t_next.scan_bypass = test_data_in;
                end
            end
            default: begin
                // Update-DR drives no cells: chain only ever observes
            end
        endcase
        // Only sample-with-high-Z floats the memory outputs
        t_next.highz = (t_next.scan_instruction == OP_SAMPLEZ);
    end

    // Power-up state comes from the first edge; there is no tap reset pin
    always_ff @(posedge test_clk) begin
        por_done_reg <= 1'b1;
        if (!por_done_reg) begin
            t_reg <= '{state: TLR, scan_instruction: OP_IDCODE,
                       default: '0};
        end else begin
            t_reg <= t_next;
        end
    end

    always_comb begin
        if (t_reg.state == SH_IR) begin
            serial_bit = t_reg.ir_shift[0];
        end else if (scan_op) begin
            serial_bit = t_reg.pin_boundary_chain[0];
        end else if (t_reg.scan_instruction == OP_IDCODE) begin
            serial_bit = t_reg.part_identification[0];
        end else begin
            serial_bit = t_reg.scan_bypass;
        end
    end

    // Output moves on the falling edge to give the tester a half period
    always_ff @(negedge test_clk) begin
        tdo_reg    <= serial_bit;
        tdo_oe_reg <= por_done_reg &&
                      (t_reg.state == SH_IR || t_reg.state == SH_DR);
    end

    assign test_data_out    = tdo_oe_reg ? tdo_reg : 1'b0;
    assign test_data_out_oe = tdo_oe_reg;

    ////////////////////////////////////////////////////////////////////////
    // High-Z level into the system clock domain
    logic hz_meta_reg, hz_sync_reg;
    always_ff @(posedge mclk) begin
        if (srst) begin
            hz_meta_reg <= 1'b0;
            hz_sync_reg <= 1'b0;
        end else if (clk_en) begin
            hz_meta_reg <= t_reg.highz;
            hz_sync_reg <= hz_meta_reg;
        end
    end
    assign outputs_high_z = hz_sync_reg;
endmodule // sram_tap_scan_registers
`default_nettype wire

/* sram_tap_scan_registers_tb.sv */
// Loads every code, checks captured IR, high-Z flag and selected chain.
// Assumes scan_tester as the far side and the checker bound below.
`default_nettype none
module sram_tap_scan_registers_tb import tap_scan_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 mclk = 1'h0;
    logic                 srst = 1'h1;
    logic                 clk_en = 1'h1;
    logic [BSR_WIDTH-1:0] io_ring = '0;
    logic [BSR_WIDTH-1:0] got;
    logic [BSR_WIDTH-1:0] pat = 69'h1_5a5a_c3c3_f00f_1234;
    logic [2:0]           codes [8] = '{OP_SAMPLEZ, OP_EXTEST, OP_SAMPLE,
                              OP_BYPASS, 3'h3, 3'h5, 3'h6, OP_IDCODE};
    wire logic            hz, tck, tms, tdi, tdo, oe;
    int                   num_errors = 0;
    int                   checks = 0;
    always #20 mclk = ~mclk;
    sram_tap_scan_registers uut (.mclk(mclk), .srst(srst), .clk_en(clk_en),
        .outputs_high_z(hz), .test_clk(tck), .test_mode_sel(tms),
        .test_data_in(tdi), .test_data_out(tdo), .test_data_out_oe(oe),
        .io_ring(io_ring));
    scan_tester tester (.test_clk(tck), .test_mode_sel(tms),
        .test_data_in(tdi), .test_data_out(tdo));
    task automatic cmp_vec(input logic [68:0] g, input logic [68:0] e);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmp_bit(input logic g, input logic e);
        cmp_vec({68'h0, g}, {68'h0, e});
    endtask
    task automatic print_verdict();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        logic [2:0] prev;
        logic [68:0] exp;
        repeat (12) @(negedge mclk);
        srst <= 1'h0;
        tester.tap_reset();
        tester.scan(1'h0, ID_WIDTH, pat, got);
        cmp_vec(got, {37'h0, ID_CODE_DEFAULT});
        prev = OP_IDCODE;
        foreach (codes[i]) begin
            @(negedge mclk) io_ring <= pat ^ {62'h0, 7'(i)};
            tester.scan(1'h1, IR_WIDTH, {66'h0, codes[i]}, got);
            cmp_vec(got, {66'h0, prev[2], IR_CAPTURE});
            repeat (4) @(negedge mclk);
            cmp_bit(hz, codes[i] == OP_SAMPLEZ);
            tester.scan(1'h0, BSR_WIDTH, ~pat, got);
            case (codes[i])
                OP_IDCODE: exp = {~pat[36:0], ID_CODE_DEFAULT};
                OP_EXTEST, OP_SAMPLEZ, OP_SAMPLE: exp = io_ring;
                default: exp = {~pat[67:0], 1'h0};
            endcase
            cmp_vec(got, exp);
            prev = codes[i];
        end
        // A frozen synchroniser must hold the flag until re-enabled
        @(negedge mclk) clk_en <= 1'h0;
        tester.scan(1'h1, IR_WIDTH, {66'h0, OP_SAMPLEZ}, got);
        repeat (4) @(negedge mclk);
        cmp_bit(hz, 1'h0);
        clk_en <= 1'h1;
        repeat (4) @(negedge mclk);
        cmp_bit(hz, 1'h1);
        srst <= 1'h1;
        @(negedge mclk) srst <= 1'h0;
        cmp_bit(hz, 1'h0);
        tester.tap_reset();
        tester.scan(1'h0, ID_WIDTH, pat, got);
        cmp_vec(got, {37'h0, ID_CODE_DEFAULT});
        print_verdict();
    end
    initial begin
        #200000;
        num_errors++;
        print_verdict();
    end
endmodule // sram_tap_scan_registers_tb
bind sram_tap_scan_registers tap_scan_checker chk (.mclk(mclk),
    .srst(srst), .clk_en(clk_en), .outputs_high_z(outputs_high_z),
    .test_clk(test_clk), .test_mode_sel(test_mode_sel),
    .test_data_out(test_data_out), .test_data_out_oe(test_data_out_oe));
`default_nettype wire

/* tap_scan_checker.sv */
// Pin-level checks of the scan port and the high-Z flag.
// Assumes the tester moves its pins while the test clock is low.
`default_nettype none
module tap_scan_checker (
    input wire logic mclk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic outputs_high_z,
    input wire logic test_clk,
    input wire logic test_mode_sel,
    input wire logic test_data_out,
    input wire logic test_data_out_oe
);
    chk_tdo_idle_zero: assert property (@(negedge test_clk)
        !test_data_out_oe |-> !test_data_out) else $error("tdo idle set");
    chk_oe_needs_low: assert property (@(negedge test_clk)
        test_data_out_oe |-> !$past(test_mode_sel)) else $error("oe early");
    chk_oe_exit_shift: assert property (@(negedge test_clk)
        test_data_out_oe && test_mode_sel |=> !test_data_out_oe)
        else $error("oe stays");
    chk_oe_fall_cause: assert property (@(negedge test_clk)
        $past(test_data_out_oe) && !test_data_out_oe |-> $past(test_mode_sel))
        else $error("oe fell");
    chk_tap_reset_idle: assert property (@(negedge test_clk)
        test_mode_sel [*5] |=> !test_data_out_oe [*4]) else $error("no reset");
    chk_highz_reset: assert property (@(posedge mclk)
        srst |=> !outputs_high_z) else $error("high-z in reset");
    chk_highz_after_reset: assert property (@(posedge mclk) disable iff (srst)
        $fell(srst) |-> !outputs_high_z [*2]) else $error("high-z early");
    chk_highz_frozen: assert property (@(posedge mclk) disable iff (srst)
        !clk_en |=> $stable(outputs_high_z)) else $error("high-z moved");
endmodule // tap_scan_checker
`default_nettype wire

/* tap_scan_pkg.sv */
// Constants and types for the serial scan port of a synchronous SRAM.
// Assumes an IEEE-style four-signal test port driven by an outside tester.
`default_nettype none
package tap_scan_pkg;
    localparam int IR_WIDTH   = 3;
    localparam int BSR_WIDTH  = 69;
    localparam int ID_WIDTH   = 32;
    localparam int RESET_ONES = 5;
    // Two lowest bits loaded in Capture-IR
    localparam logic [1:0] IR_CAPTURE = 2'h1;
    // Instruction codes
    localparam logic [2:0] OP_EXTEST  = 3'h0;
    localparam logic [2:0] OP_IDCODE  = 3'h1;
    localparam logic [2:0] OP_SAMPLEZ = 3'h2;
    localparam logic [2:0] OP_SAMPLE  = 3'h4;
    localparam logic [2:0] OP_BYPASS  = 3'h7;
    // Identification code; value is arbitrary
    localparam logic [31:0] ID_CODE_DEFAULT = 32'h0abc_d001;

    typedef enum logic [3:0] {
        TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h3, CAP_DR = 4'h2,
        SH_DR = 4'h6, EX1_DR = 4'h7, PA_DR = 4'h5, EX2_DR = 4'h4,
        UP_DR = 4'hc, SEL_IR = 4'hd, CAP_IR = 4'hf, SH_IR = 4'he,
        EX1_IR = 4'ha, PA_IR = 4'hb, EX2_IR = 4'h9, UP_IR = 4'h8
    } tap_state_e;
endpackage
`default_nettype wire
